// ==== pkg/flash_front_pkg.sv ====
// Purpose: shared constants for the serial flash bus front end
// Assumes: one system clock, link pins sampled through two flip-flops
// Notes: instruction codes and bit positions used by the front end
package flash_front_pkg;
	localparam logic [7:0] CMD_ENTER_QUAD_WIRE = 8'h38;
	localparam logic [7:0] CMD_EXIT_QUAD_WIRE  = 8'hFF;
	localparam logic [7:0] CMD_RESET_ENABLE    = 8'h66;
	localparam logic [7:0] CMD_RESET_DEVICE    = 8'h99;
	localparam logic [7:0] CMD_ENTER_ADDR4     = 8'hB7;
	localparam logic [7:0] CMD_EXIT_ADDR4      = 8'hE9;
	localparam logic [7:0] CMD_DUAL_OUT_READ   = 8'h3B;
	localparam logic [7:0] CMD_DUAL_IO_READ    = 8'hBB;
	localparam logic [7:0] CMD_QUAD_OUT_READ   = 8'h6B;
	localparam logic [7:0] CMD_QUAD_IO_READ    = 8'hEB;
	localparam logic [7:0] CMD_FAST_READ4      = 8'h0C;
	localparam logic [7:0] CMD_READ4           = 8'h13;
	localparam logic [7:0] CMD_DTR_FAST_READ   = 8'h0D;
	localparam logic [7:0] CMD_DTR_QUAD_READ   = 8'hED;
	localparam logic [7:0] CMD_WRITE_STATUS    = 8'h01;
	localparam int         ADDR3_BYTES         = 3;
	localparam int         ADDR4_BYTES         = 4;
	localparam int         DUMMY_CLOCKS        = 8;
	localparam logic [7:0] EXT_ADDR_RESET      = 8'h00;
	localparam int         SYNC_STAGES         = 2;
	localparam logic [5:0] PIN_IDLE_LEVELS     = 6'h1F;
	localparam int         CLK_FREQ_MHZ        = 200;
	localparam int         LINK_PERIOD_NS      = 160;
	localparam int         LINK_PERIOD_CYCLES  = (LINK_PERIOD_NS * CLK_FREQ_MHZ) / 1000;
	typedef enum logic [1:0] {WIDTH_ONE, WIDTH_TWO, WIDTH_FOUR} line_width_e;
endpackage

// ==== logic/pin_sync.sv ====
// Purpose: two flip-flop synchroniser for a group of link pins
// Assumes: inputs asynchronous to clock
// Notes: first stage read only by the second stage
module pin_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pinIn,
	input  wire logic [WIDTH-1:0] resetValue,
	output logic      [WIDTH-1:0] pinOut
);
	logic [WIDTH-1:0] stage1_reg;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			stage1_reg <= resetValue;
			pinOut     <= resetValue;
		end else begin
			stage1_reg <= pinIn;
			pinOut     <= stage1_reg;
		end
	end
endmodule // pin_sync

// ==== logic/serial_flash_front_end.sv ====
// Purpose: serial bus front end of a serial NOR flash: decode, modes, pause, pin muxing
// Assumes: link clock, select and data pins sampled by a much faster clock
// Notes: array, program and erase engines sit behind the request/response ports
// What this block does
// - low write guard with protect bit blocks status writes
// - quad enable turns write guard into data line 2
// - pause while selected: output off, inputs ignored
// - line 3 is pause or restart unless quad enabled
// - single mode: sample rising edge, drive falling edge
// - accept clock idle low or idle high
// - dual instructions use lines 0 and 1
// - quad instructions use all four lines
// - quad instructions need the quad enable bit
// - enter (with quad enable) and exit commands toggle four-wire instruction mode
// - four-wire mode: opcode in two clocks
// - power-up and reset leave four-wire mode
// - double rate: opcode rising, rest both edges
// - power-up address width from non-volatile bit
// - enter/exit commands switch address width, status shows it
// - three-byte mode prepends extended address register
// - some instructions always take four address bytes
// - pause starts when clock low, else next fall
// - pause ends when clock low, else next fall
// - pause only in single/dual, only selected
// - pause keeps partial instruction state
// - select high deselects, tri-states, needs fall first
// - pin select bit picks pause or restart
module serial_flash_front_end
	import flash_front_pkg::*;
#(
	parameter int ADDR_BITS = 32
) (
	input  wire logic                  clock,
	input  wire logic                  rst_n,
	input  wire logic                  linkClock,
	input  wire logic                  selectPin_n,
	input  wire logic [3:0]            dataIn,
	output logic      [3:0]            dataOut,
	output logic      [3:0]            dataOe_n,
	input  wire logic                  quad_enable_bit,
	input  wire logic                  status_protect_bit,
	input  wire logic                  powerup_addr_width_bit,
	input  wire logic                  pinFunctionRestart,
	input  wire logic [7:0]            extAddrReg,
	input  wire logic [7:0]            readData,
	output logic                       current_addr_width_bit,
	output logic                       four_wire_instruction_mode,
	output logic                       pauseActive,
	output logic                       statusWriteBlocked,
	output logic                       restartRequest,
	output logic                       cmdValid,
	output logic      [7:0]            cmdCode,
	output logic      [ADDR_BITS-1:0]  cmdAddr,
	output logic                       dataByteValid,
	output logic      [7:0]            dataByte,
	output logic                       readByteTake
);
	import flash_front_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_OPCODE, ST_ADDR, ST_DUMMY, ST_READ, ST_WRITE,
		ST_IGNORE} phase_e;

	logic [5:0] syncPins;
	logic       linkClk, selN;
	logic [3:0] dIn;
	logic       linkClkPrev_reg, selNPrev_reg;
	phase_e     phase_reg;
	logic [7:0] shift_reg, outShift_reg;
	logic [5:0] bitCount_reg;
	logic [2:0] byteCount_reg;
	logic [2:0] addrBytes_reg;
	logic       ddr_reg, resetArmed_reg, armedAfterPowerup_reg, captured_reg;
	line_width_e width_reg;
	logic [ADDR_BITS-1:0] addr_reg;

	// idle levels under reset, so release shows no false select fall
	pin_sync #(.WIDTH(6)) sync_inst (
		.clock      (clock),
		.rst_n      (rst_n),
		.pinIn      ({linkClock, selectPin_n, dataIn}),
		.resetValue (PIN_IDLE_LEVELS),
		.pinOut     (syncPins)
	);
	assign linkClk = syncPins[5];
	assign selN    = syncPins[4];
	assign dIn     = syncPins[3:0];

	wire riseEdge   = linkClk && !linkClkPrev_reg;
	wire fallEdge   = !linkClk && linkClkPrev_reg;
	wire selFall    = !selN && selNPrev_reg;
	wire selected   = !selN && armedAfterPowerup_reg;
	// pin 3 acts as pause only in non-quad, non-restart setting
	wire pauseFunc  = !quad_enable_bit && !pinFunctionRestart && width_reg != WIDTH_FOUR;
	wire restartFun = !quad_enable_bit && pinFunctionRestart;
	wire pausePin   = pauseFunc && !dIn[3];
	wire pauseOn    = pauseActive && !selN;
	// clock already low: act on pin edge at once, else wait for next fall
	wire pauseStart = selected && pausePin && !pauseActive && (!linkClk || fallEdge);
	wire pauseStop  = pauseActive && !pausePin && (!linkClk || fallEdge);
	wire shiftEn    = selected && !pauseOn && phase_reg != ST_IDLE && phase_reg != ST_IGNORE;
	wire sampleEn   = shiftEn && (riseEdge || (ddr_reg && fallEdge && phase_reg != ST_OPCODE));
	wire driveEn    = shiftEn && phase_reg == ST_READ && (fallEdge || (ddr_reg && riseEdge));

	function automatic logic [2:0] bits_per_edge(input line_width_e w);
		case (w)
			WIDTH_TWO:  bits_per_edge = 3'd2;
			WIDTH_FOUR: bits_per_edge = 3'd4;
			default:    bits_per_edge = 3'd1;
		endcase
	endfunction

	// msb first, highest line carries most significant bit
	function automatic logic [7:0] shift_in(input logic [7:0] s, input logic [3:0] d,
			input line_width_e w);
		case (w)
			WIDTH_TWO:  shift_in = {s[5:0], d[1:0]};
			WIDTH_FOUR: shift_in = {s[3:0], d[3:0]};
			default:    shift_in = {s[6:0], d[0]};
		endcase
	endfunction

	function automatic line_width_e cmd_width(input logic [7:0] c);
		if (c == CMD_DUAL_OUT_READ || c == CMD_DUAL_IO_READ)
			cmd_width = WIDTH_TWO;
		else if (c == CMD_QUAD_OUT_READ || c == CMD_QUAD_IO_READ || c == CMD_DTR_QUAD_READ)
			cmd_width = WIDTH_FOUR;
		else
			cmd_width = WIDTH_ONE;
	endfunction

	function automatic logic is_quad(input logic [7:0] c);
		is_quad = (c == CMD_QUAD_OUT_READ || c == CMD_QUAD_IO_READ || c == CMD_DTR_QUAD_READ);
	endfunction

	function automatic logic has_addr(input logic [7:0] c);
		has_addr = (c == CMD_DUAL_OUT_READ || c == CMD_DUAL_IO_READ || c == CMD_QUAD_OUT_READ
			|| c == CMD_QUAD_IO_READ || c == CMD_FAST_READ4 || c == CMD_READ4
			|| c == CMD_DTR_FAST_READ || c == CMD_DTR_QUAD_READ);
	endfunction

	// dummy phase counts sample edges, both edges in double rate, whatever the line width
	wire [5:0] step       = (phase_reg == ST_DUMMY) ? 6'd1 : {3'd0, bits_per_edge(width_reg)};
	wire [5:0] bitsNext   = bitCount_reg + step;
	wire [7:0] shiftNext  = shift_in(shift_reg, dIn, width_reg);
	wire       byteDone   = sampleEn && bitsNext[3] && phase_reg != ST_DUMMY;
	wire [7:0] opNext     = shiftNext;
	wire       opQuadBad  = is_quad(opNext) && !quad_enable_bit;
	wire       enterQw    = opNext == CMD_ENTER_QUAD_WIRE && quad_enable_bit;
	// fixed four-byte subset ignores the width setting
	wire       force4     = opNext == CMD_FAST_READ4 || opNext == CMD_READ4;
	wire [2:0] addrLen    = (force4 || current_addr_width_bit) ? 3'(ADDR4_BYTES)
		: 3'(ADDR3_BYTES);
	wire [ADDR_BITS-1:0] addrShift = {addr_reg[ADDR_BITS-9:0], shiftNext};
	// three-byte form uses extended register for the top byte
	wire [ADDR_BITS-1:0] addrFinal = (addrBytes_reg == 3'(ADDR3_BYTES))
		? {extAddrReg, addrShift[23:0]} : addrShift;
	wire       wsBlocked  = status_protect_bit && !dIn[2] && !quad_enable_bit
		&& width_reg != WIDTH_FOUR;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			linkClkPrev_reg <= 1'b0;
			selNPrev_reg    <= 1'b1;
		end else begin
			linkClkPrev_reg <= linkClk;
			selNPrev_reg    <= selN;
		end
	end

	// a select fall must be seen before any instruction is taken
	always_ff @(posedge clock) begin
		if (!rst_n)
			armedAfterPowerup_reg <= 1'b0;
		else if (selFall)
			armedAfterPowerup_reg <= 1'b1;
	end

	always_ff @(posedge clock) begin
		if (!rst_n || selN) begin
			pauseActive <= 1'b0;
		end else if (pauseStart) begin
			pauseActive <= 1'b1;
		end else if (pauseStop) begin
			pauseActive <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			restartRequest     <= 1'b0;
			statusWriteBlocked <= 1'b0;
		end else begin
			restartRequest     <= restartFun && !dIn[3];
			statusWriteBlocked <= wsBlocked;
		end
	end

	// power-up width latched after release, not under reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			captured_reg           <= 1'b0;
			current_addr_width_bit <= 1'b0;
		end else if (!captured_reg) begin
			captured_reg           <= 1'b1;
			current_addr_width_bit <= powerup_addr_width_bit;
		end else if (byteDone && phase_reg == ST_OPCODE) begin
			if (opNext == CMD_ENTER_ADDR4)
				current_addr_width_bit <= 1'b1;
			else if (opNext == CMD_EXIT_ADDR4)
				current_addr_width_bit <= 1'b0;
			else if (opNext == CMD_RESET_DEVICE && resetArmed_reg)
				current_addr_width_bit <= powerup_addr_width_bit;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			four_wire_instruction_mode <= 1'b0;
			resetArmed_reg             <= 1'b0;
		end else if (byteDone && phase_reg == ST_OPCODE) begin
			resetArmed_reg <= opNext == CMD_RESET_ENABLE;
			if (opNext == CMD_RESET_DEVICE && resetArmed_reg)
				four_wire_instruction_mode <= 1'b0;
			else if (enterQw)
				four_wire_instruction_mode <= 1'b1;
			else if (opNext == CMD_EXIT_QUAD_WIRE && four_wire_instruction_mode)
				four_wire_instruction_mode <= 1'b0;
		end
	end

	// transfer sequencer; select high drops all interface state
	always_ff @(posedge clock) begin
		if (!rst_n || selN) begin
			phase_reg     <= ST_IDLE;
			width_reg     <= WIDTH_ONE;
			bitCount_reg  <= '0;
			byteCount_reg <= '0;
			addrBytes_reg <= '0;
			shift_reg     <= '0;
			addr_reg      <= '0;
			ddr_reg       <= 1'b0;
		end else if (phase_reg == ST_IDLE) begin
			if (selected) begin
				phase_reg <= ST_OPCODE;
				width_reg <= four_wire_instruction_mode ? WIDTH_FOUR : WIDTH_ONE;
			end
		end else if (sampleEn) begin
			// paused cycles never reach here, so partial state is kept
			shift_reg    <= shiftNext;
			bitCount_reg <= byteDone ? 6'd0 : bitsNext;
			if (byteDone) begin
				case (phase_reg)
					ST_OPCODE: begin
						if (opQuadBad) begin
							phase_reg <= ST_IGNORE;
						end else if (has_addr(opNext)) begin
							phase_reg     <= ST_ADDR;
							addrBytes_reg <= addrLen;
							ddr_reg       <= opNext == CMD_DTR_FAST_READ
								|| opNext == CMD_DTR_QUAD_READ;
							if (!four_wire_instruction_mode &&
								(opNext == CMD_DUAL_IO_READ || opNext == CMD_QUAD_IO_READ
								|| opNext == CMD_DTR_QUAD_READ))
								width_reg <= cmd_width(opNext);
						end else if (opNext == CMD_WRITE_STATUS) begin
							phase_reg <= ST_WRITE;
						end else begin
							phase_reg <= ST_IGNORE;
						end
						byteCount_reg <= '0;
					end
					ST_ADDR: begin
						addr_reg      <= addrShift;
						byteCount_reg <= byteCount_reg + 3'd1;
						if (byteCount_reg + 3'd1 == addrBytes_reg) begin
							phase_reg     <= ST_DUMMY;
							bitCount_reg  <= '0;
							if (!four_wire_instruction_mode)
								width_reg <= cmd_width(cmdCode);
						end
					end
					default: ;
				endcase
			end else if (phase_reg == ST_DUMMY && bitsNext >= 6'(DUMMY_CLOCKS)) begin
				phase_reg    <= ST_READ;
				bitCount_reg <= '0;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cmdValid      <= 1'b0;
			cmdCode       <= 8'h00;
			cmdAddr       <= '0;
			dataByteValid <= 1'b0;
			dataByte      <= 8'h00;
		end else begin
			cmdValid      <= 1'b0;
			dataByteValid <= 1'b0;
			if (byteDone && phase_reg == ST_OPCODE && !opQuadBad) begin
				cmdCode  <= opNext;
				cmdValid <= !has_addr(opNext);
			end
			if (byteDone && phase_reg == ST_ADDR && byteCount_reg + 3'd1 == addrBytes_reg) begin
				cmdAddr  <= addrFinal;
				cmdValid <= 1'b1;
			end
			// status writes dropped while the guard is active
			if (byteDone && phase_reg == ST_WRITE && !wsBlocked) begin
				dataByte      <= shiftNext;
				dataByteValid <= 1'b1;
			end
		end
	end

	wire [3:0] lanesOn = (width_reg == WIDTH_FOUR) ? 4'hF
		: (width_reg == WIDTH_TWO) ? 4'h3 : 4'h2;
	wire [7:0] outShifted = (width_reg == WIDTH_FOUR) ? {outShift_reg[3:0], 4'h0}
		: (width_reg == WIDTH_TWO) ? {outShift_reg[5:0], 2'h0} : {outShift_reg[6:0], 1'b0};
	wire [3:0] outBits = (width_reg == WIDTH_FOUR) ? outShift_reg[7:4]
		: (width_reg == WIDTH_TWO) ? {2'h0, outShift_reg[7:6]} : {2'h0, outShift_reg[7], 1'b0};
	logic [5:0] outCount_reg;

	// read data shifted out msb first on the drive edge
	always_ff @(posedge clock) begin
		if (!rst_n || selN) begin
			outShift_reg <= 8'h00;
			outCount_reg <= '0;
			readByteTake <= 1'b0;
			dataOut      <= 4'h0;
		end else begin
			readByteTake <= 1'b0;
			if (driveEn) begin
				if (outCount_reg == 6'd0) begin
					readByteTake <= 1'b1;
					dataOut      <= (width_reg == WIDTH_FOUR) ? readData[7:4]
						: (width_reg == WIDTH_TWO) ? {2'h0, readData[7:6]}
						: {2'h0, readData[7], 1'b0};
					outShift_reg <= readData << bits_per_edge(width_reg);
				end else begin
					dataOut      <= outBits;
					outShift_reg <= outShifted;
				end
				outCount_reg <= (outCount_reg + step >= 6'd8) ? 6'd0 : outCount_reg + step;
			end
		end
	end

	// outputs float when deselected, paused or not reading
	always_ff @(posedge clock) begin
		if (!rst_n)
			dataOe_n <= 4'hF;
		else if (selN || pauseOn || phase_reg != ST_READ)
			dataOe_n <= 4'hF;
		else
			dataOe_n <= ~lanesOn;
	end
endmodule // serial_flash_front_end

// ==== testbench/serial_flash_front_end_sva.sv ====
// Purpose: port checks for the serial flash front end
// Assumes: link pins reach the logic within four clocks
// Notes: bound to every front end instance
module serial_flash_front_end_sva (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       selectPin_n,
	input wire logic [3:0] dataIn,
	input wire logic [3:0] dataOe_n,
	input wire logic       quad_enable_bit,
	input wire logic       status_protect_bit,
	input wire logic       powerup_addr_width_bit,
	input wire logic       pinFunctionRestart,
	input wire logic       current_addr_width_bit,
	input wire logic       four_wire_instruction_mode,
	input wire logic       pauseActive,
	input wire logic       statusWriteBlocked,
	input wire logic       restartRequest
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	AST_RESET_IDLE: assert property (
		$rose(rst_n) |-> dataOe_n == 4'hF && !four_wire_instruction_mode)
		else $error("outputs not idle after reset");
	AST_POWERUP_WIDTH: assert property (
		$rose(rst_n) |=> current_addr_width_bit == $past(powerup_addr_width_bit))
		else $error("address width not taken at power-up");
	AST_GUARD_BLOCKS: assert property (
		(!quad_enable_bit && status_protect_bit && !dataIn[2])[*5] |-> statusWriteBlocked)
		else $error("guard low did not block status writes");
	AST_QUAD_NO_GUARD: assert property (
		quad_enable_bit[*5] |-> !statusWriteBlocked)
		else $error("guard still active with quad enable");
	AST_QUAD_NO_PAUSE: assert property (
		quad_enable_bit[*5] |-> !pauseActive && !restartRequest)
		else $error("line 3 function active with quad enable");
	AST_PAUSE_SELECTED: assert property (
		selectPin_n[*5] |-> !pauseActive)
		else $error("pause while deselected");
	AST_PAUSE_TRISTATE: assert property (
		pauseActive[*2] |-> dataOe_n == 4'hF)
		else $error("output driven during pause");
	AST_DESELECT_TRISTATE: assert property (
		selectPin_n[*5] |-> dataOe_n == 4'hF)
		else $error("output driven while deselected");
	AST_RESTART_PIN: assert property (
		(pinFunctionRestart && !quad_enable_bit && !dataIn[3])[*5] |-> restartRequest)
		else $error("restart pin ignored");
	AST_RESTART_NO_PAUSE: assert property (
		pinFunctionRestart[*5] |-> !pauseActive)
		else $error("pause with restart function chosen");
	AST_QUAD_ENTRY: assert property (
		$rose(four_wire_instruction_mode) |-> quad_enable_bit)
		else $error("four wire mode without quad enable");
endmodule // serial_flash_front_end_sva

bind serial_flash_front_end serial_flash_front_end_sva u_sva (
	.clock(clock), .rst_n(rst_n), .selectPin_n(selectPin_n), .dataIn(dataIn),
	.dataOe_n(dataOe_n), .quad_enable_bit(quad_enable_bit),
	.status_protect_bit(status_protect_bit), .powerup_addr_width_bit(powerup_addr_width_bit),
	.pinFunctionRestart(pinFunctionRestart), .current_addr_width_bit(current_addr_width_bit),
	.four_wire_instruction_mode(four_wire_instruction_mode), .pauseActive(pauseActive),
	.statusWriteBlocked(statusWriteBlocked), .restartRequest(restartRequest)
);

// ==== testbench/flash_bus_master.sv ====
// Purpose: bus master model driving the flash pins
// Assumes: link clock period of 32 system clocks
// Notes: released lines take pinLevel, the board pull level
module flash_bus_master (
	input  wire logic       clock,
	input  wire logic [3:0] dataOut,
	input  wire logic [3:0] dataOe_n,
	output logic            linkClock,
	output logic            selectPin_n,
	output logic [3:0]      dataIn
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       idleHigh = 1'b0;
	logic [3:0] drive    = 4'h0;
	logic [3:0] masterOe = 4'h0;
	logic [3:0] pinLevel = 4'hF;
	initial begin
		linkClock = 1'b0;
		selectPin_n = 1'b1;
	end
	// device lane wins when it drives
	assign dataIn = (~dataOe_n & dataOut) | (dataOe_n & masterOe & drive)
		| (dataOe_n & ~masterOe & pinLevel);
	task automatic half();
		repeat (16) @(posedge clock);
		#1;
	endtask
	task automatic frameStart(input logic cpolHigh);
		idleHigh = cpolHigh;
		linkClock = cpolHigh;
		half();
		selectPin_n = 1'b0;
		half();
	endtask
	task automatic frameEnd();
		half();
		linkClock = idleHigh;
		masterOe = 4'h0;
		half();
		selectPin_n = 1'b1;
		half();
	endtask
	// data set while clock low, device samples the rise
	task automatic shiftBits(input logic [7:0] b, input int nBits, input int lanes);
		logic [7:0] s;
		for (int k = 0; k < nBits; k += lanes) begin
			s = b >> (8 - lanes - k);
			linkClock = 1'b0;
			masterOe = (lanes == 4) ? 4'hF : 4'h1;
			drive = (lanes == 4) ? s[3:0] : {3'b000, s[0]};
			half();
			linkClock = 1'b1;
			half();
		end
	endtask
endmodule // flash_bus_master

// ==== testbench/serial_flash_front_end_bench.sv ====
// Purpose: self-checking bench for the serial flash front end
// Assumes: master model on the pins, config bits driven here
// Notes: scenarios as tasks, verdict from summarize
module serial_flash_front_end_bench import flash_front_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock, rst_n, quadEnable, protectBit, powerupWide, restartSel;
	logic [7:0]  extAddr, readByte, lastCode, got, lastData;
	logic [31:0] lastAddr;
	wire logic   linkClock, selectPin_n, addrWide, fourWire, pauseActive, writeBlocked;
	wire logic   restartRequest, cmdValid, dataByteValid, readTake;
	wire logic [3:0] dataIn, dataOut, dataOe_n;
	wire logic [7:0] cmdCode, dataByte;
	wire logic [31:0] cmdAddr;
	int n_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int writes = 0;
	int takes = 0;
	flash_bus_master u_flash_bus_master (.clock(clock), .dataOut(dataOut), .dataOe_n(dataOe_n),
		.linkClock(linkClock), .selectPin_n(selectPin_n), .dataIn(dataIn));
	serial_flash_front_end u_serial_flash_front_end (.clock(clock), .rst_n(rst_n),
		.linkClock(linkClock), .selectPin_n(selectPin_n), .dataIn(dataIn), .dataOut(dataOut),
		.dataOe_n(dataOe_n), .quad_enable_bit(quadEnable), .status_protect_bit(protectBit),
		.powerup_addr_width_bit(powerupWide), .pinFunctionRestart(restartSel),
		.extAddrReg(extAddr), .readData(readByte), .current_addr_width_bit(addrWide),
		.four_wire_instruction_mode(fourWire), .pauseActive(pauseActive),
		.statusWriteBlocked(writeBlocked), .restartRequest(restartRequest),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdAddr(cmdAddr),
		.dataByteValid(dataByteValid), .dataByte(dataByte), .readByteTake(readTake));
	task automatic checkBit(input string what, input logic expected, input logic seen);
		samples_checked++;
		if (seen !== expected) begin
			n_errors++;
			$display("mismatch %s expected %b seen %b", what, expected, seen);
		end
	endtask
	task automatic checkWord(input string what, input logic [31:0] expected,
			input logic [31:0] seen);
		samples_checked++;
		if (seen !== expected) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, expected, seen);
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic resetDut(input logic wide);
		rst_n = 1'b0;
		powerupWide = wide;
		repeat (8) @(posedge clock);
		#1;
		rst_n = 1'b1;
		u_flash_bus_master.half();
		checkBit("address width", wide, addrWide);
		checkBit("four wire", 1'b0, fourWire);
		checkWord("enables", 32'h0000000F, {28'h0000000, dataOe_n});
	endtask
	task automatic sendCmd(input logic [7:0] op, input int lanes, input logic cpol);
		u_flash_bus_master.frameStart(cpol);
		u_flash_bus_master.shiftBits(op, 8, lanes);
		u_flash_bus_master.frameEnd();
	endtask
	task automatic testAddrMode();
		sendCmd(CMD_EXIT_ADDR4, 1, 1'b0);
		checkBit("address width", 1'b0, addrWide);
		sendCmd(CMD_ENTER_ADDR4, 1, 1'b1);
		checkBit("address width", 1'b1, addrWide);
		checkWord("opcode", {24'h000000, CMD_ENTER_ADDR4}, {24'h000000, lastCode});
		sendCmd(CMD_EXIT_ADDR4, 1, 1'b1);
		checkBit("address width", 1'b0, addrWide);
	endtask
	task automatic testFourWire();
		sendCmd(CMD_ENTER_QUAD_WIRE, 1, 1'b0);
		checkBit("four wire", 1'b0, fourWire);
		quadEnable = 1'b1;
		sendCmd(CMD_ENTER_QUAD_WIRE, 1, 1'b0);
		checkBit("four wire", 1'b1, fourWire);
		sendCmd(CMD_EXIT_QUAD_WIRE, 4, 1'b0);
		checkBit("four wire", 1'b0, fourWire);
		sendCmd(CMD_ENTER_QUAD_WIRE, 1, 1'b0);
		sendCmd(CMD_RESET_ENABLE, 4, 1'b0);
		sendCmd(CMD_RESET_DEVICE, 4, 1'b0);
		checkBit("four wire", 1'b0, fourWire);
		quadEnable = 1'b0;
	endtask
	task automatic writeStatus(input logic [7:0] v);
		u_flash_bus_master.frameStart(1'b0);
		u_flash_bus_master.shiftBits(CMD_WRITE_STATUS, 8, 1);
		u_flash_bus_master.shiftBits(v, 8, 1);
		u_flash_bus_master.frameEnd();
	endtask
	task automatic testGuard();
		protectBit = 1'b1;
		u_flash_bus_master.pinLevel[2] = 1'b0;
		u_flash_bus_master.half();
		checkBit("write blocked", 1'b1, writeBlocked);
		writeStatus(8'h3C);
		checkWord("status writes", 32'h00000000, writes);
		quadEnable = 1'b1;
		u_flash_bus_master.half();
		checkBit("write blocked", 1'b0, writeBlocked);
		quadEnable = 1'b0;
		protectBit = 1'b0;
		u_flash_bus_master.half();
		checkBit("write blocked", 1'b0, writeBlocked);
		writeStatus(8'hC3);
		checkWord("status writes", 32'h00000001, writes);
		checkWord("status data", 32'h000000C3, {24'h000000, lastData});
		u_flash_bus_master.pinLevel[2] = 1'b1;
	endtask
	// pause mid-opcode, with the clock first high then low
	task automatic testPause();
		u_flash_bus_master.frameStart(1'b0);
		u_flash_bus_master.shiftBits(CMD_EXIT_ADDR4, 4, 1);
		u_flash_bus_master.pinLevel[3] = 1'b0;
		u_flash_bus_master.half();
		checkBit("pause", 1'b0, pauseActive);
		u_flash_bus_master.linkClock = 1'b0;
		u_flash_bus_master.half();
		checkBit("pause", 1'b1, pauseActive);
		checkWord("enables", 32'h0000000F, {28'h0000000, dataOe_n});
		u_flash_bus_master.linkClock = 1'b1;
		u_flash_bus_master.half();
		u_flash_bus_master.linkClock = 1'b0;
		u_flash_bus_master.half();
		u_flash_bus_master.pinLevel[3] = 1'b1;
		u_flash_bus_master.half();
		checkBit("pause", 1'b0, pauseActive);
		u_flash_bus_master.shiftBits({CMD_EXIT_ADDR4[3:0], 4'h0}, 4, 1);
		u_flash_bus_master.frameEnd();
		checkBit("address width", 1'b0, addrWide);
		sendCmd(CMD_EXIT_ADDR4, 1, 1'b0);
		restartSel = 1'b1;
		u_flash_bus_master.pinLevel[3] = 1'b0;
		u_flash_bus_master.half();
		checkBit("restart", 1'b1, restartRequest);
		quadEnable = 1'b1;
		u_flash_bus_master.half();
		checkBit("restart", 1'b0, restartRequest);
		quadEnable = 1'b0;
		restartSel = 1'b0;
		u_flash_bus_master.half();
		checkBit("restart", 1'b0, restartRequest);
		u_flash_bus_master.pinLevel[3] = 1'b1;
	endtask
	task automatic readFrame(input logic [7:0] op, input logic [31:0] addr, input int nAddr,
			input int lanes);
		u_flash_bus_master.frameStart(1'b0);
		u_flash_bus_master.shiftBits(op, 8, 1);
		for (int k = nAddr - 1; k >= 0; k--) begin
			u_flash_bus_master.shiftBits(addr[8*k+:8], 8, 1);
		end
		u_flash_bus_master.shiftBits(8'h00, 8, 1);
		u_flash_bus_master.masterOe = 4'h0;
		for (int k = 0; k < 8; k += lanes) begin
			u_flash_bus_master.linkClock = 1'b0;
			u_flash_bus_master.half();
			checkBit("drive enable", 1'b0, dataOe_n[1]);
			got = (got << lanes) | {6'h00, (lanes == 2) ? dataIn[1:0] : {1'b0, dataIn[1]}};
			u_flash_bus_master.linkClock = 1'b1;
			u_flash_bus_master.half();
		end
		u_flash_bus_master.frameEnd();
	endtask
	task automatic testReads();
		readFrame(CMD_FAST_READ4, 32'h12345678, 4, 1);
		checkWord("address", 32'h12345678, lastAddr);
		checkWord("read data", 32'h000000A5, {24'h000000, got});
		readFrame(CMD_DUAL_OUT_READ, 32'h00ABCDEF, 3, 2);
		checkWord("address", 32'h5AABCDEF, lastAddr);
		checkWord("read data", 32'h000000A5, {24'h000000, got});
		checkWord("byte takes", 32'h00000004, takes);
	endtask
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles++;
		if (cmdValid === 1'b1) begin
			lastCode = cmdCode;
			lastAddr = cmdAddr;
		end
		if (dataByteValid === 1'b1) begin
			writes++;
			lastData = dataByte;
		end
		if (readTake === 1'b1)
			takes++;
		if (cycles == 40000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		rst_n = 1'b0;
		quadEnable = 1'b0;
		protectBit = 1'b0;
		powerupWide = 1'b1;
		restartSel = 1'b0;
		extAddr = 8'h5A;
		readByte = 8'hA5;
		resetDut(1'b1);
		testAddrMode();
		testFourWire();
		testGuard();
		testPause();
		testReads();
		quadEnable = 1'b1;
		sendCmd(CMD_ENTER_QUAD_WIRE, 1, 1'b0);
		quadEnable = 1'b0;
		resetDut(1'b0);
		summarize();
	end
endmodule // serial_flash_front_end_bench
